// File: shared/fes_cfg.svh
`ifndef FES_CFG_SVH
`define FES_CFG_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define FES_CMD_READ_ARRAY   8'hFF
`define FES_CMD_READ_STATUS  8'h70
`define FES_CMD_CLEAR_STATUS 8'h50
`define FES_CMD_ERASE_SETUP  8'h20
`define FES_CMD_CONFIRM      8'hD0
`define FES_CMD_SUSPEND      8'hB0
`define FES_CMD_WRITE_SETUP  8'h40
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define FES_SR_READY    7
`define FES_SR_PAUSED   6
`define FES_SR_ERASE    5
`define FES_SR_PROGRAM  4
`define FES_SR_SUPPLY   3
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FES_REG_CTRL    4'h0
`define FES_REG_ADDR    4'h4
`define FES_REG_DATA    4'h8
`define FES_REG_STAT    4'hC
`define FES_REG_IRQ     4'h0
`define FES_REG_MASK    4'h4
// Control bits: op code field, start and auto clear
`define FES_OP_LSB      0
`define FES_OP_MSB      2
`define FES_CTRL_GO     3
`define FES_CTRL_AUTO   4
// Operation codes
`define FES_OP_ERASE    3'h1
`define FES_OP_PROGRAM  3'h2
`define FES_OP_CLEAR    3'h3
`define FES_OP_ARRAY    3'h4
`define FES_OP_SUSPEND  3'h5
`define FES_OP_RESUME   3'h6
`define FES_OP_READ     3'h7
// Interrupt bits
`define FES_IRQ_DONE    0
`define FES_IRQ_ERR     1
`define FES_IRQ_SUPPLY  2
`define FES_IRQ_W       3
// ----------------------------------------
// Bus timing, ns and derived cycles
// ----------------------------------------
`define FES_CLK_NS      25
`define FES_TWP_NS      50
`define FES_TWPH_NS     20
`define FES_TACE_NS     90
`define FES_CYC(ns) (((ns) + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_TWP_CYC     4'(`FES_CYC(`FES_TWP_NS))
`define FES_TWPH_CYC    4'(`FES_CYC(`FES_TWPH_NS))
`define FES_TACE_CYC    4'(`FES_CYC(`FES_TACE_NS))
`define FES_CNT_ONE     4'h1
`endif

// File: shared/fes_pkg.sv
package fes_pkg;
	typedef enum logic [5:0] {
		FES_IDLE  = 6'h01,
		FES_CMD1  = 6'h02,
		FES_CMD2  = 6'h04,
		FES_POLL  = 6'h08,
		FES_CHECK = 6'h10,
		FES_CLR   = 6'h20
	} fes_state_e;
	typedef logic [3:0] fes_cnt_t;
endpackage : fes_pkg

// File: design/fes_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "fes_cfg.svh"
// ----------------------------------------
// One flash bus cycle, write or read
// ----------------------------------------
module fes_bus_cycle (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic [19:0] addr,
	input  wire logic [7:0]  wdata,
	output logic             done,
	output logic [7:0]       rdata,
	output logic [19:0]      f_addr,
	output logic [7:0]       f_dq_o,
	output logic             f_dq_oe,
	input  wire logic [7:0]  f_dq_i,
	output logic             f_ce_n,
	output logic             f_we_n,
	output logic             f_oe_n
);
	// Phase: 0 idle, 1 strobe low, 2 recovery high
	logic [1:0]         ph_r;
	fes_pkg::fes_cnt_t  cnt_r;
	logic               wr_r;
	wire  cnt_end = (cnt_r == `FES_CNT_ONE);
	wire  fin     = (ph_r == 2'h2) && cnt_end;
	assign done   = fin;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ph_r    <= 2'h0;
			cnt_r   <= 4'h0;
			wr_r    <= 1'b0;
			f_addr  <= 20'h00000;
			f_dq_o  <= 8'h00;
			f_dq_oe <= 1'b0;
			f_ce_n  <= 1'b1;
			f_we_n  <= 1'b1;
			f_oe_n  <= 1'b1;
			rdata   <= 8'h00;
		end else if (ph_r == 2'h0) begin
			if (start) begin
				// Address and data set up with the strobe edge itself
				ph_r    <= 2'h1;
				wr_r    <= is_write;
				cnt_r   <= is_write ? `FES_TWP_CYC : `FES_TACE_CYC;
				f_addr  <= addr;
				f_dq_o  <= wdata;
				f_dq_oe <= is_write;
				f_ce_n  <= 1'b0;
				f_we_n  <= ~is_write;
				f_oe_n  <= is_write;
			end
		end else if (!cnt_end) begin
			cnt_r <= cnt_r - `FES_CNT_ONE;
		end else if (ph_r == 2'h1) begin
			// Data held one extra cycle past the rising strobe
			ph_r   <= 2'h2;
			cnt_r  <= `FES_TWPH_CYC;
			f_ce_n <= 1'b1;
			f_we_n <= 1'b1;
			f_oe_n <= 1'b1;
			if (!wr_r)
				rdata <= f_dq_i;
		end else begin
			ph_r    <= 2'h0;
			f_dq_oe <= 1'b0;
		end
	end
endmodule : fes_bus_cycle
`default_nettype wire

// File: design/fes_host.sv
// What this block does
// - Erase is setup code then confirm at block
// - Poll status until ready, or suspend instead
// - Read-array code returns to array reads
// - Skip full check, still clear supply fault
// - A supply fault refuses later erase and program until cleared
// - Clear-status is one write of its code
`timescale 1ns/1ps
`default_nettype none
`include "fes_cfg.svh"
module fes_host (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	output logic [19:0]      f_addr,
	output logic [7:0]       f_dq_o,
	output logic             f_dq_oe,
	input  wire logic [7:0]  f_dq_i,
	output logic             f_ce_n,
	output logic             f_we_n,
	output logic             f_oe_n
);
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic        ack_r;
	logic [4:0]  ctrl_r;
	logic [19:0] addr_r;
	logic [7:0]  data_r;
	logic [7:0]  stat_r;
	logic        busy_r;
	logic        refused_r;
	logic [2:0]  irq_r;
	logic [2:0]  mask_r;
	logic        bank_r;
	wire req     = wb_cyc_i && wb_stb_i && !ack_r;
	wire wr      = req && wb_we_i && wb_sel_i[0];
	wire wr_ctrl = wr && (wb_adr_i == `FES_REG_CTRL) && !bank_r;
	wire go      = wr_ctrl && wb_dat_i[`FES_CTRL_GO] && !busy_r;
	wire [2:0] op_req = wb_dat_i[`FES_OP_MSB:`FES_OP_LSB];
	wire wr_irq  = wr && (wb_adr_i == `FES_REG_IRQ) && bank_r;
	wire wr_mask = wr && (wb_adr_i == `FES_REG_MASK) && bank_r;
	wire wr_bank = wr && (wb_adr_i == `FES_REG_STAT) && !bank_r;
	assign wb_ack_o = ack_r;
	assign irq      = |(irq_r & mask_r);
	// Fault lock: host tracks the device's supply refusal
	wire is_modify = (op_req == `FES_OP_ERASE) || (op_req == `FES_OP_PROGRAM);
	wire blocked   = is_modify && stat_r[`FES_SR_SUPPLY];
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	fes_pkg::fes_state_e st_r;
	fes_pkg::fes_state_e st_nxt;
	logic       cyc_start;
	logic       cyc_we;
	logic [7:0] cyc_wd;
	logic       cyc_done;
	logic [7:0] cyc_rd;
	logic [2:0] op_r;
	function automatic logic [7:0] first_code(input logic [2:0] op);
		unique case (op)
			`FES_OP_ERASE:   first_code = `FES_CMD_ERASE_SETUP;
			`FES_OP_PROGRAM: first_code = `FES_CMD_WRITE_SETUP;
			`FES_OP_CLEAR:   first_code = `FES_CMD_CLEAR_STATUS;
			`FES_OP_SUSPEND: first_code = `FES_CMD_SUSPEND;
			`FES_OP_RESUME:  first_code = `FES_CMD_CONFIRM;
			`FES_OP_READ:    first_code = `FES_CMD_READ_STATUS;
			default:         first_code = `FES_CMD_READ_ARRAY;
		endcase
	endfunction : first_code
	wire two_cyc = (op_r == `FES_OP_ERASE) || (op_r == `FES_OP_PROGRAM);
	wire polls   = two_cyc || (op_r == `FES_OP_SUSPEND) ||
	               (op_r == `FES_OP_RESUME) || (op_r == `FES_OP_READ);
	wire ready   = cyc_rd[`FES_SR_READY];
	wire paused  = cyc_rd[`FES_SR_PAUSED];
	wire any_err = |cyc_rd[`FES_SR_ERASE:`FES_SR_SUPPLY];
	// Resume returns to busy polling; suspend may end with paused set
	always_comb begin
		st_nxt    = st_r;
		cyc_start = 1'b0;
		cyc_we    = 1'b1;
		cyc_wd    = first_code(op_r);
		unique case (st_r)
			fes_pkg::FES_IDLE: begin
			end
			fes_pkg::FES_CMD1: begin
				cyc_start = 1'b1;
				if (cyc_done)
					st_nxt = two_cyc ? fes_pkg::FES_CMD2 :
					         polls ? fes_pkg::FES_POLL :
					         fes_pkg::FES_IDLE;
			end
			fes_pkg::FES_CMD2: begin
				cyc_start = 1'b1;
				cyc_wd    = (op_r == `FES_OP_ERASE) ? `FES_CMD_CONFIRM : data_r;
				if (cyc_done)
					st_nxt = fes_pkg::FES_POLL;
			end
			fes_pkg::FES_POLL: begin
				cyc_start = 1'b1;
				cyc_we    = 1'b0;
				// Device answers status on every read here
				if (cyc_done && ready)
					st_nxt = fes_pkg::FES_CHECK;
			end
			fes_pkg::FES_CHECK: begin
				st_nxt = (ctrl_r[`FES_CTRL_AUTO] && stat_r[`FES_SR_SUPPLY]) ?
				         fes_pkg::FES_CLR : fes_pkg::FES_IDLE;
			end
			fes_pkg::FES_CLR: begin
				cyc_start = 1'b1;
				cyc_wd    = `FES_CMD_CLEAR_STATUS;
				if (cyc_done)
					st_nxt = fes_pkg::FES_IDLE;
			end
		endcase
	end
	wire finish = (st_r == fes_pkg::FES_CHECK);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_r      <= fes_pkg::FES_IDLE;
			ack_r     <= 1'b0;
			ctrl_r    <= 5'h00;
			addr_r    <= 20'h00000;
			data_r    <= 8'h00;
			op_r      <= 3'h0;
			busy_r    <= 1'b0;
			refused_r <= 1'b0;
			bank_r    <= 1'b0;
		end else begin
			st_r  <= st_nxt;
			ack_r <= req;
			if (wr_bank)
				bank_r <= wb_dat_i[0];
			if (wr && wb_adr_i == `FES_REG_ADDR && !bank_r)
				addr_r <= wb_dat_i[19:0];
			if (wr && wb_adr_i == `FES_REG_DATA && !bank_r)
				data_r <= wb_dat_i[7:0];
			if (wr_ctrl)
				ctrl_r <= wb_dat_i[4:0];
			// Busy refuses orders; device not ready yet
			if (go) begin
				refused_r <= blocked;
				if (!blocked) begin
					op_r   <= op_req;
					busy_r <= 1'b1;
					st_r   <= fes_pkg::FES_CMD1;
				end
			end else if (st_nxt == fes_pkg::FES_IDLE && st_r != fes_pkg::FES_IDLE)
				busy_r <= 1'b0;
		end
	end
	// Status mirror: last device status, cleared by clear op or auto clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			stat_r <= 8'h00;
		else if (cyc_done && st_r == fes_pkg::FES_POLL)
			stat_r <= cyc_rd;
		else if (cyc_done && cyc_wd == `FES_CMD_CLEAR_STATUS &&
		         st_r != fes_pkg::FES_CMD2) // Data byte, not a command
			stat_r <= 8'h00;
	end
	// ----------------------------------------
	// Interrupts, write one to clear, set wins
	// ----------------------------------------
	wire [2:0] ev = {finish && stat_r[`FES_SR_SUPPLY],
	                 finish && any_err, finish};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_r  <= 3'h0;
			mask_r <= 3'h0;
		end else begin
			irq_r <= (irq_r & ~(wr_irq ? wb_dat_i[2:0] : 3'h0)) | ev;
			if (wr_mask)
				mask_r <= wb_dat_i[2:0];
		end
	end
	// Read mux
	always_comb begin
		wb_dat_o = 32'h00000000;
		if (ack_r) begin
			if (bank_r)
				wb_dat_o = (wb_adr_i == `FES_REG_IRQ) ? {29'h0, irq_r} :
				           (wb_adr_i == `FES_REG_MASK) ? {29'h0, mask_r} :
				           32'h00000000;
			else
				unique case (wb_adr_i)
					`FES_REG_CTRL: wb_dat_o = {27'h0, ctrl_r};
					`FES_REG_ADDR: wb_dat_o = {12'h0, addr_r};
					`FES_REG_DATA: wb_dat_o = {24'h0, data_r};
					`FES_REG_STAT: wb_dat_o = {20'h0, bank_r, refused_r,
					                           busy_r, 1'b0, stat_r[7:3], 3'h0};
					default:       wb_dat_o = 32'h00000000;
				endcase
		end
	end
	fes_bus_cycle u_cyc (
		.clock    (clock),
		.rst      (rst),
		.start    (cyc_start),
		.is_write (cyc_we),
		.addr     (addr_r),
		.wdata    (cyc_wd),
		.done     (cyc_done),
		.rdata    (cyc_rd),
		.f_addr   (f_addr),
		.f_dq_o   (f_dq_o),
		.f_dq_oe  (f_dq_oe),
		.f_dq_i   (f_dq_i),
		.f_ce_n   (f_ce_n),
		.f_we_n   (f_we_n),
		.f_oe_n   (f_oe_n)
	);
endmodule : fes_host
`default_nettype wire

// File: sim/fes_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// Host side checks
// ---
module fes_host_chk (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic [7:0] f_dq_o,
	input wire logic       f_dq_oe,
	input wire logic       f_ce_n,
	input wire logic       f_we_n,
	input wire logic       f_oe_n
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	ack_answer_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	strobe_width_a: assert property (
		$fell(f_we_n) |=> (!f_we_n && !f_ce_n) ##1 f_we_n)
		else $error("write strobe width");
	read_write_excl_a: assert property (f_we_n || f_oe_n)
		else $error("read and write strobes together");
	bus_release_a: assert property (!f_oe_n |-> !f_dq_oe && !f_ce_n)
		else $error("data bus driven in read");
	write_drive_a: assert property (!f_we_n |-> f_dq_oe && !f_ce_n)
		else $error("write strobe without data drive");
	erase_confirm_a: assert property (
		$fell(f_we_n) && f_dq_o == 8'h20 |->
		##[3:30] ($fell(f_we_n) && f_dq_o == 8'hD0))
		else $error("erase not confirmed");
	poll_after_a: assert property (
		$fell(f_we_n) && f_dq_o == 8'hD0 |-> ##[2:30] $fell(f_oe_n))
		else $error("no status poll");
	clear_single_a: assert property (
		$fell(f_we_n) && f_dq_o == 8'h50 |=> ##1 f_we_n [*3])
		else $error("clear not single");
	cover property ($fell(f_we_n) && f_dq_o == 8'h20);
	cover property ($fell(f_we_n) && f_dq_o == 8'h50);
	cover property ($fell(f_oe_n));
endmodule : fes_host_chk
bind fes_host fes_host_chk u_chk (.clock, .rst, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .f_dq_o, .f_dq_oe, .f_ce_n, .f_we_n, .f_oe_n);
`default_nettype wire

// File: sim/fes_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// Flash device model
// ---
module fes_flash_model (
	input wire logic        clock,
	input wire logic        f_ce_n,
	input wire logic        f_we_n,
	input wire logic        f_oe_n,
	input wire logic        vpp_bad,
	input wire logic        slow,
	input wire logic [19:0] f_addr,
	input wire logic [7:0]  f_dq_o,
	output logic [7:0]      f_dq_i
);
	logic [7:0]  sr = 8'h00;
	logic [7:0]  busy = 8'h00;
	logic [7:0]  q = 8'h00;
	logic [7:0]  cmd;
	logic [19:0] adr;
	logic [19:0] blk = 20'h0;
	logic [1:0]  pend = 2'h0;
	logic        wl = 1'b0;
	logic        arr = 1'b1;
	int          erases = 0;
	int          clears = 0;
	int          viol = 0;
	wire         rd = !f_ce_n && !f_oe_n;
	wire [7:0]   val = arr ? f_addr[7:0] : {busy == 8'h00, sr[6:0]};
	// Released bus shows inverse, so stale data never passes
	assign f_dq_i = rd ? val : ~q;
	task automatic exec();
		arr <= 1'b0;
		if (busy != 8'h00 && cmd != 8'hB0)
			viol++;
		else if (pend != 2'h0) begin
			pend <= 2'h0;
			if (pend == 2'h1 && cmd != 8'hD0)
				sr[5:4] <= 2'h3;
			else if (sr[3])
				viol++;
			else begin
				busy <= slow ? 8'h3C : 8'h03;
				sr[3] <= sr[3] | vpp_bad;
				sr[5] <= sr[5] | (vpp_bad && pend == 2'h1);
				sr[4] <= sr[4] | (vpp_bad && pend == 2'h2);
				if (pend == 2'h1) begin
					erases++;
					blk <= adr;
				end
			end
		end else case (cmd)
			8'h20: pend <= 2'h1;
			8'h40: pend <= 2'h2;
			8'h50: begin
				sr[5:3] <= 3'h0;
				clears++;
			end
			8'hFF: arr <= 1'b1;
			8'hB0: if (busy != 8'h00) begin
				busy <= 8'h00;
				sr[6] <= 1'b1;
			end
			8'hD0: sr[6] <= 1'b0;
			default: ;
		endcase
	endtask : exec
	always @(posedge clock) begin
		if (busy != 8'h00)
			busy <= busy - 8'h01;
		if (rd)
			q <= val;
		wl <= !f_we_n && !f_ce_n;
		if (!f_we_n && !f_ce_n) begin
			cmd <= f_dq_o;
			adr <= f_addr;
		end else if (wl)
			exec();
	end
endmodule : fes_flash_model
`default_nettype wire

// File: sim/fes_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fes_host_bench;
	logic        clock;
	logic        rst;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [3:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        irq;
	logic [19:0] f_addr;
	logic [7:0]  f_dq_o;
	logic        f_dq_oe;
	logic [7:0]  f_dq_i;
	logic        f_ce_n;
	logic        f_we_n;
	logic        f_oe_n;
	logic        vpp_bad;
	logic        slow;
	logic [31:0] rd;
	logic [7:0]  ops [4] = '{8'h0A, 8'h0D, 8'h0E, 8'h0F};
	int          failures = 0;
	int          num_checks = 0;
	fes_host DUT (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .f_addr,
		.f_dq_o, .f_dq_oe, .f_dq_i, .f_ce_n, .f_we_n, .f_oe_n);
	fes_flash_model u_flash (.clock, .f_ce_n, .f_we_n, .f_oe_n, .vpp_bad,
		.slow, .f_addr, .f_dq_o, .f_dq_i);
	// ---
	// Tasks
	// ---
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		@(posedge clock);
		while (wb_ack_o !== 1'b1)
			@(posedge clock);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask : wb
	task run(input logic [7:0] c);
		int n;
		wb(1'b1, 4'h0, {24'h0, c});
		n = 0;
		rd[9] = 1'b1;
		while (rd[9] !== 1'b0 && n < 400) begin
			wb(1'b0, 4'hC, 32'h0);
			n++;
		end
		if (rd[9] !== 1'b0) begin
			failures++;
			$display("[FAIL] %0t busy never cleared", $time);
		end
	endtask : run
	task give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	// ---
	// Clock, watchdog, tests
	// ---
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		vpp_bad = 1'b0;
		slow = 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk({f_ce_n, f_we_n, f_oe_n, f_dq_oe, irq}, 32'h1C);
		wb(1'b1, 4'h4, 32'h3F123);
		run(8'h09);
		chk(rd[7:0], 8'h80);
		chk(u_flash.busy, 8'h00);
		chk(u_flash.blk, 20'h3F123);
		slow <= 1'b0;
		wb(1'b1, 4'h4, 32'h00ABC);
		run(8'h09);
		chk(u_flash.erases, 2);
		chk(u_flash.blk, 20'h00ABC);
		foreach (ops[i]) begin
			run(ops[i]);
			chk(rd[7:0], 8'h80);
		end
		run(8'h0C);
		chk(u_flash.arr, 1'b1);
		run(8'h0F);
		chk(u_flash.arr, 1'b0);
		vpp_bad <= 1'b1;
		run(8'h09);
		chk(rd[10:0], 11'h0A8);
		run(8'h09);
		chk(rd[10:0], 11'h4A8);
		chk(u_flash.erases, 3);
		run(8'h0B);
		chk(rd[7:0], 8'h00);
		chk(u_flash.sr[5:3], 3'h0);
		chk(u_flash.clears, 1);
		run(8'h19);
		chk(u_flash.sr[3], 1'b0);
		chk(u_flash.clears, 2);
		chk(u_flash.viol, 0);
		vpp_bad <= 1'b0;
		wb(1'b1, 4'hC, 32'h1);
		wb(1'b1, 4'h4, 32'h0);
		chk(irq, 1'b0);
		wb(1'b1, 4'h4, 32'h4);
		chk(irq, 1'b1);
		wb(1'b0, 4'h0, 32'h0);
		chk(rd[2:0], 3'h7);
		wb(1'b1, 4'h0, 32'h7);
		chk(irq, 1'b0);
		wb(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h0);
		give_verdict();
	end
endmodule : fes_host_bench
`default_nettype wire
